// [roh_pkg.sv]
// Package for the receive overhead serial ports.
// Assumes a byte-wide overhead feed from the receive framer on ref_clk.
package roh_pkg;
	localparam int ROH_NUM_PATHS = 16;
	localparam int ROH_TOH_BYTES = 36 * 9;
	localparam int ROH_POH_BYTES = 9;
	localparam int ROH_BYTE_BITS = 8;
	localparam int ROH_MARK_BITS = 8;
	localparam int ROH_MEM_DEPTH = 512;
	localparam logic [2:0] ROH_BIT_LAST = 3'h7;
	// Byte indices of the order-wire bytes E1, F1, E2, and rows and columns of line channel bytes
	localparam logic [8:0] ROH_IDX_E1 = 9'h090;
	localparam logic [8:0] ROH_IDX_F1 = 9'h050;
	localparam logic [8:0] ROH_IDX_E2 = 9'h112;
	localparam logic [8:0] ROH_IDX_D4_ROW = 9'h05;
	localparam logic [8:0] ROH_IDX_D12_ROW = 9'h07;
	localparam logic [8:0] ROH_ROW_BYTES = 9'h024;
	localparam logic [8:0] ROH_D_COL_A = 9'h000;
	localparam logic [8:0] ROH_D_COL_B = 9'h00C;
	localparam logic [8:0] ROH_D_COL_C = 9'h018;
	typedef enum logic [1:0] {roh_idle, roh_mark, roh_shift} roh_state_t;
	typedef enum logic [1:0] {roh_pidle, roh_pshift} roh_pstate_t;
endpackage

// [roh_mem.sv]
// Byte store for one frame of transport overhead.
// Assumes the reader starts only after the frame-done toggle has crossed.
`timescale 1ns/10ps
module roh_mem import roh_pkg::*; #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 512
) (
	input wire logic clk, // Write clock
	input wire logic rd_clk, // Read clock
	input wire logic wr_en, // Write strobe
	input wire logic [$clog2(DEPTH)-1:0] wr_addr, // Write address
	input wire logic [WIDTH-1:0] wr_data, // Write data
	input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Read address
	output logic [WIDTH-1:0] rd_data // Registered read data
);
	if (DEPTH < ROH_TOH_BYTES) begin : g_bad_depth
		$error("roh_mem depth too small");
	end
	logic [WIDTH-1:0] store [DEPTH];
	always_ff @(posedge clk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
	end
	// Read register sits in the reader's domain, so rd_data never crosses
	always_ff @(posedge rd_clk) begin
		rd_data <= store[rd_addr];
	end
endmodule

// [roh_path_port.sv]
// One path overhead serial port on its own divided clock.
// Assumes bytes arrive on ref_clk with a strobe per byte.
`timescale 1ns/10ps
module roh_path_port import roh_pkg::*; (
	input wire logic ref_clk, // System clock
	input wire logic rst, // Sync reset
	input wire logic byte_stb, // New path byte
	input wire logic byte_first, // Byte is J1
	input wire logic [7:0] byte_data, // Path byte
	input wire logic locked, // Frame found
	output logic path_oh_clock, // Port clock
	output logic path_oh_out, // Serial data
	output logic path_oh_valid, // Data valid
	output logic path_oh_frame_marker // J1 marker
);
	typedef struct packed {
		logic clk_q;
		logic [7:0] hold;
		logic hold_full;
		logic hold_first;
		logic [7:0] shreg;
		logic [2:0] bitc;
		logic first;
		roh_pstate_t st;
		logic out;
		logic valid;
		logic mark;
	} roh_pp_t;
	roh_pp_t q, next_q;
	always_comb begin
		next_q = q;
		next_q.clk_q = ~q.clk_q;
		if (byte_stb) begin
			next_q.hold = byte_data;
			next_q.hold_full = 1'b1;
			next_q.hold_first = byte_first;
		end
		// Update on the falling edge of the port clock [R13]
		if (q.clk_q) begin
			case (q.st)
				roh_pidle: begin
					if (q.hold_full && locked) begin
						next_q.shreg = q.hold;
						next_q.first = q.hold_first;
						next_q.hold_full = byte_stb;
						next_q.bitc = 3'h0;
						next_q.st = roh_pshift;
					end
				end
				roh_pshift: begin
					next_q.shreg = {q.shreg[6:0], 1'b0};
					next_q.bitc = q.bitc + 3'h1;
					if (q.bitc == ROH_BIT_LAST) begin
						if (q.hold_full && locked) begin
							next_q.shreg = q.hold;
							next_q.first = q.hold_first;
							next_q.hold_full = byte_stb;
						end else begin
							next_q.st = roh_pidle;
						end
					end
				end
				default: next_q.st = roh_pidle;
			endcase
			next_q.out = (next_q.st == roh_pshift) ? next_q.shreg[7] : 1'b0; // [R13]
			next_q.valid = (next_q.st == roh_pshift) && locked; // [R15] [R17]
			next_q.mark = (next_q.st == roh_pshift) && next_q.first && locked; // [R16] [R17]
		end
		if (rst) begin
			next_q = '0;
		end
	end
	always_ff @(posedge ref_clk) begin
		q <= next_q;
	end
	assign path_oh_clock = q.clk_q;
	assign path_oh_out = q.out;
	assign path_oh_valid = q.valid;
	assign path_oh_frame_marker = q.mark;
endmodule

// [roh_serial_ports.sv]
// Receive overhead serial ports: transport, line channel, order-wire, path.
// Assumes framer bytes on ref_clk; transport side runs on oh_link_clk.
// Operation
// R1: Transport overhead bits leave serially, changing on falling overhead clock edges.
// R2: Receiver samples overhead data on rising overhead clock edges.
// R3: Overhead valid high exactly while an overhead bit is driven.
// R4: Frame marker high one period, one period before first bit.
// R5: Eight-period A1 marker rejected; one-period early marker chosen.
// R6: Line channel valid pulses with each line channel bit, falling edges.
// R7: Line channel carries only bytes D4 through D12.
// R8: HDLC receiver latches line data when valid sampled high.
// R9: Order-wire marker high one period with first E1 bit.
// R10: Order-wire carries E1, F1, E2 with valid asserted.
// R11: Order-wire outputs change only on falling overhead clock edges.
// R12: Order-wire receiver latches from marker until valid falls.
// R13: Each path port shifts its bytes on its own clock falling edges.
// R14: Path receiver samples on rising edges of its port clock.
// R15: Path valid high while genuine path data is driven.
// R16: Path marker high while J1 is shifted out.
// R17: Valid and markers low in reset or before frame lock.
`timescale 1ns/10ps
module roh_serial_ports import roh_pkg::*; #(
	parameter int NUM_PATHS = ROH_NUM_PATHS
) (
	input wire logic ref_clk, // 100 MHz system clock
	input wire logic rst, // Sync reset, active high
	input wire logic oh_link_clk, // Transport overhead port clock
	input wire logic oh_link_rst, // Sync reset on link clock
	input wire logic toh_stb, // Transport byte strobe
	input wire logic [8:0] toh_idx, // Byte index in frame
	input wire logic [7:0] toh_data, // Transport byte
	input wire logic frame_locked, // Frame located
	input wire logic [NUM_PATHS-1:0] poh_stb, // Path byte strobes
	input wire logic [NUM_PATHS-1:0] poh_first, // Path byte is J1
	input wire logic [NUM_PATHS*8-1:0] poh_data, // Path bytes
	output logic oh_serial_clock, // Overhead clock out
	output logic oh_serial_out, // Overhead data
	output logic oh_serial_valid, // Overhead valid
	output logic oh_frame_marker, // Frame marker
	output logic line_comm_out, // Line channel data
	output logic line_comm_valid, // Line channel valid
	output logic orderwire_out, // Order-wire data
	output logic orderwire_valid, // Order-wire valid
	output logic orderwire_frame_marker, // E1 marker
	output logic [NUM_PATHS-1:0] path_oh_clock, // Path clocks
	output logic [NUM_PATHS-1:0] path_oh_out, // Path data
	output logic [NUM_PATHS-1:0] path_oh_valid, // Path valid
	output logic [NUM_PATHS-1:0] path_oh_frame_marker // Path J1 markers
);
	localparam int ROH_MAX_PATHS = 64;

	// Refuse sizes the logic cannot serve
	if (NUM_PATHS < 1 || NUM_PATHS > ROH_MAX_PATHS) begin : g_bad_paths
		$error("roh NUM_PATHS out of range");
	end
	if (ROH_MEM_DEPTH < ROH_TOH_BYTES) begin : g_bad_depth
		$error("roh frame store too small");
	end

	function automatic logic is_line_dcc(input logic [8:0] idx);
		logic [8:0] row;
		logic [8:0] col;
		row = idx / ROH_ROW_BYTES;
		col = idx % ROH_ROW_BYTES;
		is_line_dcc = row >= ROH_IDX_D4_ROW && row <= ROH_IDX_D12_ROW
			&& (col == ROH_D_COL_A || col == ROH_D_COL_B || col == ROH_D_COL_C);
	endfunction

	function automatic logic is_orderwire(input logic [8:0] idx);
		is_orderwire = idx == ROH_IDX_E1 || idx == ROH_IDX_F1 || idx == ROH_IDX_E2;
	endfunction

	// Data pin shows the shift bit only while its port is active
	function automatic logic gate_bit(input logic en, input logic b);
		gate_bit = en ? b : 1'b0;
	endfunction

	// Write side: store a frame, then hand its completion over by toggle
	typedef struct packed {
		logic wr_en;
		logic [8:0] wr_addr;
		logic [7:0] wr_data;
		logic frame_tog;
		logic lock_q;
	} roh_wr_t;
	roh_wr_t w, next_w;
	always_comb begin
		next_w = w;
		next_w.wr_en = toh_stb;
		next_w.wr_addr = toh_idx;
		next_w.wr_data = toh_data;
		next_w.lock_q = frame_locked;
		if (toh_stb && toh_idx == 9'(ROH_TOH_BYTES - 1) && frame_locked) begin
			next_w.frame_tog = ~w.frame_tog;
		end
		if (rst) begin
			next_w = '0;
		end
	end
	always_ff @(posedge ref_clk) begin
		w <= next_w;
	end

	// Read side on the link clock
	logic [7:0] rd_data;
	typedef struct packed {
		logic [2:0] tog_sync;
		logic [1:0] lock_sync;
		roh_state_t st;
		logic [8:0] rd_addr;
		logic [8:0] cur_idx;
		logic [2:0] bitc;
		logic [7:0] shreg;
		logic loaded;
		logic clk_q;
		logic out;
		logic valid;
		logic mark;
		logic ldcc;
		logic ldcc_v;
		logic ow;
		logic ow_v;
		logic ow_fp;
		logic start_pend;
	} roh_rd_t;
	roh_rd_t r, next_r;
	logic locked_l;
	logic bit_now;
	logic ow_byte;
	logic dcc_byte;
	assign locked_l = r.lock_sync[1];
	always_comb begin
		next_r = r;
		next_r.tog_sync = {r.tog_sync[1:0], w.frame_tog};
		next_r.lock_sync = {r.lock_sync[0], w.lock_q};
		next_r.clk_q = ~r.clk_q;
		bit_now = 1'b0;
		ow_byte = 1'b0;
		dcc_byte = 1'b0;
		// Work happens as the output clock falls [R1] [R11]
		if (r.clk_q) begin
			next_r.mark = 1'b0;
			case (r.st)
				roh_idle: begin
					next_r.rd_addr = 9'h000;
					if (r.start_pend && locked_l) begin
						next_r.start_pend = 1'b0;
						next_r.st = roh_mark;
						next_r.mark = 1'b1; // [R4] [R5]
					end
				end
				roh_mark: begin
					next_r.st = roh_shift;
					next_r.shreg = rd_data;
					next_r.cur_idx = 9'h000;
					next_r.bitc = 3'h0;
					next_r.rd_addr = 9'h001;
					bit_now = 1'b1;
				end
				roh_shift: begin
					next_r.shreg = {r.shreg[6:0], 1'b0};
					next_r.bitc = r.bitc + 3'h1;
					bit_now = 1'b1;
					if (r.bitc == ROH_BIT_LAST) begin
						if (r.cur_idx == 9'(ROH_TOH_BYTES - 1)) begin
							next_r.st = roh_idle;
							bit_now = 1'b0;
						end else begin
							next_r.shreg = rd_data;
							next_r.cur_idx = r.cur_idx + 9'h001;
							next_r.rd_addr = r.rd_addr + 9'h001;
						end
					end
				end
				default: next_r.st = roh_idle;
			endcase
			if (!locked_l) begin
				next_r.st = roh_idle;
				next_r.start_pend = 1'b0;
				bit_now = 1'b0;
				next_r.mark = 1'b0; // [R17]
			end
			dcc_byte = is_line_dcc(next_r.cur_idx);
			ow_byte = is_orderwire(next_r.cur_idx);
			next_r.out = gate_bit(bit_now, next_r.shreg[7]); // [R1]
			next_r.valid = bit_now; // [R3] [R17]
			next_r.ldcc = gate_bit(bit_now && dcc_byte, next_r.shreg[7]); // [R7]
			next_r.ldcc_v = bit_now && dcc_byte; // [R6] [R7]
			next_r.ow = gate_bit(bit_now && ow_byte, next_r.shreg[7]); // [R10]
			next_r.ow_v = bit_now && ow_byte; // [R10] [R11]
			next_r.ow_fp = bit_now && next_r.cur_idx == ROH_IDX_E1
				&& next_r.bitc == 3'h0; // [R9]
		end
		// Toggle edge lasts one link cycle; hold it until a falling edge takes it
		if (r.tog_sync[2] != r.tog_sync[1] && locked_l) begin
			next_r.start_pend = 1'b1;
		end
		if (oh_link_rst) begin
			next_r = '0;
		end
	end
	always_ff @(posedge oh_link_clk) begin
		r <= next_r;
	end

	roh_mem #(.WIDTH(ROH_BYTE_BITS), .DEPTH(ROH_MEM_DEPTH)) u_mem (
		.clk(ref_clk),
		.rd_clk(oh_link_clk),
		.wr_en(w.wr_en),
		.wr_addr(w.wr_addr),
		.wr_data(w.wr_data),
		.rd_addr(r.rd_addr),
		.rd_data(rd_data)
	);

	assign oh_serial_clock = r.clk_q;
	assign oh_serial_out = r.out;
	assign oh_serial_valid = r.valid;
	assign oh_frame_marker = r.mark;
	assign line_comm_out = r.ldcc;
	assign line_comm_valid = r.ldcc_v;
	assign orderwire_out = r.ow;
	assign orderwire_valid = r.ow_v;
	assign orderwire_frame_marker = r.ow_fp;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PATHS; gi++) begin : g_path
			roh_path_port u_port (
				.ref_clk(ref_clk),
				.rst(rst),
				.byte_stb(poh_stb[gi]),
				.byte_first(poh_first[gi]),
				.byte_data(poh_data[gi*ROH_BYTE_BITS +: ROH_BYTE_BITS]),
				.locked(frame_locked),
				.path_oh_clock(path_oh_clock[gi]),
				.path_oh_out(path_oh_out[gi]),
				.path_oh_valid(path_oh_valid[gi]),
				.path_oh_frame_marker(path_oh_frame_marker[gi])
			);
		end
	endgenerate
endmodule

// [roh_serial_ports_props.sv]
// Checker for the receive overhead serial ports.
// Bound into roh_serial_ports; sees its ports only.
`timescale 1ns/10ps
module roh_serial_ports_props import roh_pkg::*; #(
	parameter int NUM_PATHS = ROH_NUM_PATHS
) (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Reset
	input wire logic oh_link_clk, // Link clock
	input wire logic oh_link_rst, // Link reset
	input wire logic oh_serial_clock, // Port clock
	input wire logic oh_serial_out, // Data
	input wire logic oh_serial_valid, // Valid
	input wire logic oh_frame_marker, // Marker
	input wire logic line_comm_out, // Data
	input wire logic line_comm_valid, // Valid
	input wire logic orderwire_out, // Data
	input wire logic orderwire_valid, // Valid
	input wire logic orderwire_frame_marker, // Marker
	input wire logic [NUM_PATHS-1:0] path_oh_clock, // Clocks
	input wire logic [NUM_PATHS-1:0] path_oh_out, // Data
	input wire logic [NUM_PATHS-1:0] path_oh_valid, // Valid
	input wire logic [NUM_PATHS-1:0] path_oh_frame_marker // Markers
);
	property p_fal;
		@(posedge oh_link_clk) disable iff (oh_link_rst)
		$changed({oh_serial_out, oh_serial_valid, oh_frame_marker}) |-> $fell(oh_serial_clock);
	endproperty
	a_fal: assert property (p_fal) else $error("overhead moved off fall");
	property p_mrk;
		@(posedge oh_link_clk) disable iff (oh_link_rst)
		$rose(oh_frame_marker) |-> !oh_serial_valid ##1 oh_frame_marker
			##1 (!oh_frame_marker && oh_serial_valid);
	endproperty
	a_mrk: assert property (p_mrk) else $error("marker shape");
	property p_len;
		@(posedge oh_link_clk) disable iff (oh_link_rst)
		oh_frame_marker && $past(oh_frame_marker) |-> !$past(oh_frame_marker, 2);
	endproperty
	a_len: assert property (p_len) else $error("marker too long");
	property p_chg;
		@(posedge oh_link_clk) disable iff (oh_link_rst)
		$changed({line_comm_out, line_comm_valid, orderwire_out, orderwire_valid,
			orderwire_frame_marker}) |-> $fell(oh_serial_clock);
	endproperty
	a_chg: assert property (p_chg) else $error("port moved off fall");
	property p_owm;
		@(posedge oh_link_clk) disable iff (oh_link_rst)
		$rose(orderwire_frame_marker) |-> orderwire_valid ##2 !orderwire_frame_marker;
	endproperty
	a_owm: assert property (p_owm) else $error("order-wire marker");
	property p_rsl;
		@(posedge oh_link_clk)
		oh_link_rst |=> !oh_serial_valid && !oh_frame_marker && !line_comm_valid && !orderwire_valid;
	endproperty
	a_rsl: assert property (p_rsl) else $error("active in reset");
	property p_pth;
		@(posedge ref_clk) disable iff (rst)
		$changed({path_oh_out[0], path_oh_valid[0]}) |-> $fell(path_oh_clock[0]);
	endproperty
	a_pth: assert property (p_pth) else $error("path moved off fall");
	property p_pjm;
		@(posedge ref_clk) disable iff (rst)
		$rose(path_oh_frame_marker[0]) |-> path_oh_valid[0];
	endproperty
	a_pjm: assert property (p_pjm) else $error("path marker");
endmodule
bind roh_serial_ports roh_serial_ports_props #(.NUM_PATHS(NUM_PATHS)) props_i (.*);

// [roh_capture.sv]
// Far-end capture logic for all overhead ports.
// Samples on rising port clocks; the bench reads its state.
`timescale 1ns/10ps
module roh_capture import roh_pkg::*; #(
	parameter int NUM_PATHS = ROH_NUM_PATHS
) (
	input wire logic oh_serial_clock, // Clock
	input wire logic oh_serial_out, // Data
	input wire logic oh_serial_valid, // Valid
	input wire logic oh_frame_marker, // Marker
	input wire logic line_comm_out, // Data
	input wire logic line_comm_valid, // Valid
	input wire logic orderwire_out, // Data
	input wire logic orderwire_valid, // Valid
	input wire logic orderwire_frame_marker, // Marker
	input wire logic [NUM_PATHS-1:0] path_oh_clock, // Clocks
	input wire logic [NUM_PATHS-1:0] path_oh_out, // Data
	input wire logic [NUM_PATHS-1:0] path_oh_valid, // Valid
	input wire logic [NUM_PATHS-1:0] path_oh_frame_marker // Markers
);
	logic [7:0] toh [ROH_TOH_BYTES];
	logic [71:0] lsr;
	logic [7:0] ow;
	logic [23:0] ows;
	logic ow_on = 0;
	logic mk_prev = 0;
	int nb = 0;
	int nl = 0;
	int nw = 0;
	int nwall = 0;
	int first = -1;
	wire [16*NUM_PATHS-1:0] psr;
	wire [8*NUM_PATHS-1:0] pmk;
	always @(posedge oh_serial_clock) begin
		if (mk_prev)
			first = oh_serial_valid ? nb : -2;
		mk_prev = oh_frame_marker;
		if (oh_serial_valid) begin
			if (nb < ROH_TOH_BYTES * ROH_BYTE_BITS)
				toh[nb / 8][7 - nb % 8] = oh_serial_out;
			nb++;
		end
		if (line_comm_valid) begin
			lsr = {lsr[70:0], line_comm_out};
			nl++;
		end
		nwall += orderwire_valid;
		if (orderwire_valid)
			ows = {ows[22:0], orderwire_out};
		if (orderwire_valid && orderwire_frame_marker)
			ow_on = 1;
		if (!orderwire_valid || nw == 8)
			ow_on = 0;
		if (ow_on) begin
			ow = {ow[6:0], orderwire_out};
			nw++;
		end
	end
	for (genvar i = 0; i < NUM_PATHS; i++) begin : g_p
		logic [15:0] sr = '0;
		logic [7:0] mk = '0;
		always @(posedge path_oh_clock[i]) begin
			if (path_oh_valid[i])
				sr <= {sr[14:0], path_oh_out[i]};
			if (path_oh_frame_marker[i] && path_oh_valid[i])
				mk <= mk + 8'h01;
		end
		assign psr[16*i+:16] = sr;
		assign pmk[8*i+:8] = mk;
	end
endmodule

// [tb_top.sv]
// Bench for the receive overhead serial ports.
// Drives framer bytes; judges what the capture model saw.
`timescale 1ns/10ps
module tb_top import roh_pkg::*; ();
	logic ref_clk = 0;
	logic oh_link_clk = 0;
	logic rst = 1;
	logic oh_link_rst = 1;
	logic toh_stb = 0;
	logic [8:0] toh_idx = '0;
	logic [7:0] toh_data = '0;
	logic frame_locked = 0;
	logic [15:0] poh_stb = '0;
	logic [15:0] poh_first = '0;
	logic [127:0] poh_data = '0;
	logic oh_serial_clock, oh_serial_out, oh_serial_valid, oh_frame_marker;
	logic line_comm_out, line_comm_valid;
	logic orderwire_out, orderwire_valid, orderwire_frame_marker;
	logic [15:0] path_oh_clock, path_oh_out, path_oh_valid, path_oh_frame_marker;
	int num_errors = 0;
	int num_checks = 0;
	always #5 ref_clk = ~ref_clk;
	always #62.5 oh_link_clk = ~oh_link_clk;
	roh_serial_ports roh_serial_ports_i (.*);
	roh_capture cap_i (.*);
	task automatic check(logic [71:0] seen, logic [71:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	function automatic logic [7:0] pat(int i);
		return 8'(i * 7 + 8'h3C);
	endfunction
	task automatic send_frame;
		for (int i = 0; i < ROH_TOH_BYTES; i++) begin
			@(posedge ref_clk);
			toh_stb <= 1;
			toh_idx <= 9'(i);
			toh_data <= pat(i);
		end
		@(posedge ref_clk);
		toh_stb <= 0;
	endtask
	task automatic unlocked_quiet;
		send_frame();
		repeat (300) @(posedge ref_clk);
		check(cap_i.nb + cap_i.nl + cap_i.nwall, 0);
	endtask
	task automatic toh_frame;
		logic [71:0] e;
		int k;
		frame_locked <= 1;
		send_frame();
		for (k = 0; k < 80000 && cap_i.nb < 2592; k++)
			@(posedge ref_clk);
		if (k == 80000) begin
			num_errors++;
			tally_and_finish();
		end
		for (int i = 0; i < ROH_TOH_BYTES; i++)
			check(cap_i.toh[i], pat(i));
		check(cap_i.first, 0);
		repeat (100) @(posedge ref_clk);
		check(cap_i.nb, 2592);
		for (int r = ROH_IDX_D4_ROW; r <= ROH_IDX_D12_ROW; r++)
			for (int c = 0; c < 3; c++)
				e = {e[63:0], pat(r * ROH_ROW_BYTES + c * ROH_D_COL_B)};
		check(cap_i.nl, 72);
		check(cap_i.lsr, e);
		check(cap_i.ow, pat(ROH_IDX_E1));
		check(cap_i.nwall, 24);
		check(cap_i.ows, {pat(ROH_IDX_F1), pat(ROH_IDX_E1), pat(ROH_IDX_E2)});
	endtask
	task automatic path_ports;
		logic [127:0] a, b;
		for (int i = 0; i < 16; i++) begin
			a[8*i+:8] = 8'(i * 17 + 8'h21);
			b[8*i+:8] = 8'(i * 5 + 8'hC3);
		end
		poh_stb <= '1;
		poh_first <= '1;
		poh_data <= a;
		@(posedge ref_clk);
		poh_stb <= '0;
		repeat (30) @(posedge ref_clk);
		poh_stb <= '1;
		poh_first <= '0;
		poh_data <= b;
		@(posedge ref_clk);
		poh_stb <= '0;
		repeat (60) @(posedge ref_clk);
		for (int i = 0; i < 16; i++) begin
			check(cap_i.psr[16*i+:16], {a[8*i+:8], b[8*i+:8]});
			check(cap_i.pmk[8*i+:8], ROH_BYTE_BITS);
		end
	endtask
	initial begin
		repeat (2) @(posedge oh_link_clk);
		oh_link_rst <= 0;
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		rst <= 0;
		repeat (30) @(posedge ref_clk);
		unlocked_quiet();
		toh_frame();
		path_ports();
		tally_and_finish();
	end
endmodule
